// File: ulm_pkg.sv
// constants shared by the line status and modem control block
package ulm_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADR_W = 8;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned REG_W = 8;
    localparam int unsigned IDX_W = 6;
    localparam int unsigned ADR_LSB = 2;
    localparam int unsigned MC_W = 5;
    localparam int unsigned ML_W = 4;
    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_MODEM_CONTROL = 6'h04;
    localparam logic [IDX_W-1:0] IDX_LINE_STATUS = 6'h05;
    localparam logic [IDX_W-1:0] IDX_MODEM_LEVELS = 6'h06;
    // line_status fields
    localparam int unsigned LS_RDY = 0;
    localparam int unsigned LS_OVR = 1;
    localparam int unsigned LS_PAR = 2;
    localparam int unsigned LS_FRM = 3;
    localparam int unsigned LS_BRK = 4;
    localparam int unsigned LS_HBE = 5;
    localparam int unsigned LS_IDLE = 6;
    localparam int unsigned LS_FERR = 7;
    // modem_control fields
    localparam int unsigned MC_DTR = 0;
    localparam int unsigned MC_RTS = 1;
    localparam int unsigned MC_RI = 2;
    localparam int unsigned MC_IRQ = 3;
    localparam int unsigned MC_LOOP = 4;
    // modem level vector order, also bits 4..7 of the levels register
    localparam int unsigned ML_CTS = 0;
    localparam int unsigned ML_DSR = 1;
    localparam int unsigned ML_RI = 2;
    localparam int unsigned ML_DCD = 3;
    localparam int unsigned ML_SHIFT = 4;
    // reset values
    localparam logic [MC_W-1:0] MC_RESET = 5'h00;
    localparam logic HBE_RESET = 1'b1;
    localparam logic IDLE_RESET = 1'b1;
    localparam logic PIN_IDLE = 1'b1;
    localparam logic [ML_W-1:0] ML_RESET = 4'h0;
    localparam logic [DATA_W-1:0] DAT_RESET = 32'h0000_0000;
endpackage

// File: ulm_wb_port.sv
// classic wishbone slave front end: ack and one-cycle access strobes
module ulm_wb_port (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ulm_pkg::ADR_W-1:0] i_wb_adr,
    output logic o_wb_ack,
    output logic o_rd_pulse,
    output logic o_wr_pulse,
    output logic [ulm_pkg::IDX_W-1:0] o_index
);
    typedef struct packed {
        logic ack;
    } ulm_port_state_type;

    ulm_port_state_type state_reg;
    ulm_port_state_type state_next;
    logic take;

    // a request is taken once; the ack cycle blocks a second take
    assign take = i_wb_cyc & i_wb_stb & ~state_reg.ack;
    assign o_rd_pulse = take & ~i_wb_we;
    assign o_wr_pulse = take & i_wb_we;
    assign o_index = i_wb_adr[ulm_pkg::ADR_W-1:ulm_pkg::ADR_LSB];
    assign o_wb_ack = state_reg.ack;

    always_comb begin
        state_next = state_reg;
        state_next.ack = take;
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

// File: ulm_core.sv
// line status and modem control registers with loopback routing
//
// Operation
// RQ1 - fifo mode: summary flag sets while any queued byte holds an error
// RQ2 - status read clears summary only if no error remains; single mode reads 0
// RQ3 - idle flag is 1 when holding stage and shift register are both empty
// RQ4 - single mode: empty flag sets on load into shifter; may raise interrupt
// RQ5 - fifo mode: empty flag follows fifo empty; host data write clears it
// RQ6 - break flag sets when line stays space for a whole character
// RQ7 - framing flag sets when a character lacks a valid stop bit
// RQ8 - parity flag sets when a character has a wrong parity bit
// RQ9 - fifo mode: error flags describe the head character, not the newest
// RQ10 - overrun flag sets when an unread character is overwritten
// RQ11 - status read clears break, framing, parity and overrun flags
// RQ12 - data ready is 1 while any received character waits
// RQ13 - loopback holds serial output at 1 and cuts serial input
// RQ14 - loopback drives handshake outputs inactive
// RQ15 - loopback feeds control bits 0..3 to dsr, cts, ri, carrier
// RQ16 - apart from rerouting, loopback leaves transfer and interrupts unchanged
// RQ17 - interrupt output is enabled only while control bit 3 is 1
// RQ18 - control bit 2 only feeds ring indicator in loopback
// RQ19 - request-to-send pin is the inverse of control bit 1
// RQ20 - terminal-ready pin is the inverse of control bit 0
// RQ21 - loopback: status level bits equal control bits 3, 2, 0, 1
// RQ22 - read-to-clear acts once per read, after value is captured
module ulm_core (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ulm_pkg::ADR_W-1:0] i_wb_adr,
    input wire logic [ulm_pkg::SEL_W-1:0] i_wb_sel,
    input wire logic [ulm_pkg::DATA_W-1:0] i_wb_dat,
    output logic [ulm_pkg::DATA_W-1:0] o_wb_dat,
    output logic o_wb_ack,
    // mode from the fifo control logic
    input wire logic i_fifo_mode,
    // receive side
    input wire logic i_rx_head_load,
    input wire logic i_rx_head_parity_err,
    input wire logic i_rx_head_frame_err,
    input wire logic i_rx_head_break,
    input wire logic i_rx_overrun,
    input wire logic i_rx_data_avail,
    input wire logic i_rx_fifo_err_present,
    // transmit side
    input wire logic i_tx_write,
    input wire logic i_tx_load,
    input wire logic i_tx_fifo_empty,
    input wire logic i_tx_shift_empty,
    input wire logic i_tx_serial,
    input wire logic i_holding_empty_irq_enable,
    // interrupt request from the interrupt status logic
    input wire logic i_irq_request,
    // line pins
    input wire logic i_serial_input,
    output logic o_serial_output,
    output logic o_rx_serial,
    input wire logic i_cts_n,
    input wire logic i_dsr_n,
    input wire logic i_ri_n,
    input wire logic i_dcd_n,
    output logic o_dtr_n,
    output logic o_rts_n,
    output logic o_irq,
    // to the modem status and interrupt logic
    output logic [ulm_pkg::ML_W-1:0] o_modem_levels,
    output logic [ulm_pkg::REG_W-1:0] o_line_status,
    output logic o_holding_empty_irq,
    output logic o_loopback
);
    typedef struct packed {
        logic rdy;
        logic ovr;
        logic par;
        logic frm;
        logic brk;
        logic hbe;
        logic idle;
        logic ferr;
        logic [ulm_pkg::MC_W-1:0] mctl;
        logic [ulm_pkg::DATA_W-1:0] dat;
        logic ser_out;
        logic rxs;
        logic dtr_n;
        logic rts_n;
        logic irq;
        logic hei;
        logic [ulm_pkg::ML_W-1:0] lvl;
    } ulm_core_state_type;

    ulm_core_state_type state_reg;
    ulm_core_state_type state_next;
    logic rd_pulse;
    logic wr_pulse;
    logic [ulm_pkg::IDX_W-1:0] index;
    logic [ulm_pkg::REG_W-1:0] status_now;
    logic [ulm_pkg::REG_W-1:0] rdata;
    logic loop;
    logic ls_read;

    // active-high level of a modem input: control bit in loopback, pin otherwise
    function automatic logic modem_level(
        input logic in_loop,
        input logic ctl_bit,
        input logic pin_n
    );
        logic lvl;
        lvl = in_loop ? ctl_bit : ~pin_n;
        return lvl;
    endfunction

    // register select, shared by the read mux, the write decode and read-to-clear
    function automatic logic reg_hit(
        input logic [ulm_pkg::IDX_W-1:0] idx,
        input logic [ulm_pkg::IDX_W-1:0] target
    );
        logic hit;
        hit = (idx == target);
        return hit;
    endfunction

    ulm_wb_port u_port (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_wb_cyc(i_wb_cyc),
        .i_wb_stb(i_wb_stb),
        .i_wb_we(i_wb_we),
        .i_wb_adr(i_wb_adr),
        .o_wb_ack(o_wb_ack),
        .o_rd_pulse(rd_pulse),
        .o_wr_pulse(wr_pulse),
        .o_index(index)
    );

    assign loop = state_reg.mctl[ulm_pkg::MC_LOOP];
    assign ls_read = rd_pulse & reg_hit(index, ulm_pkg::IDX_LINE_STATUS);

    always_comb begin
        status_now = '0;
        status_now[ulm_pkg::LS_RDY] = state_reg.rdy;
        status_now[ulm_pkg::LS_OVR] = state_reg.ovr;
        status_now[ulm_pkg::LS_PAR] = state_reg.par;
        status_now[ulm_pkg::LS_FRM] = state_reg.frm;
        status_now[ulm_pkg::LS_BRK] = state_reg.brk;
        status_now[ulm_pkg::LS_HBE] = state_reg.hbe;
        status_now[ulm_pkg::LS_IDLE] = state_reg.idle;
        status_now[ulm_pkg::LS_FERR] = state_reg.ferr;
    end

    always_comb begin
        rdata = '0;
        if (reg_hit(index, ulm_pkg::IDX_MODEM_CONTROL)) begin
            rdata[ulm_pkg::MC_W-1:0] = state_reg.mctl;
        end else if (reg_hit(index, ulm_pkg::IDX_LINE_STATUS)) begin
            rdata = status_now;
        end else if (reg_hit(index, ulm_pkg::IDX_MODEM_LEVELS)) begin
            rdata[ulm_pkg::ML_SHIFT +: ulm_pkg::ML_W] = state_reg.lvl;
        end
    end

    always_comb begin
        state_next = state_reg;

        // bus: the value is captured on the same edge that applies the clear
        if (rd_pulse) begin
            state_next.dat = '0;
            state_next.dat[ulm_pkg::REG_W-1:0] = rdata; // [RQ22]
        end
        if (wr_pulse && reg_hit(index, ulm_pkg::IDX_MODEM_CONTROL) && i_wb_sel[0]) begin
            state_next.mctl = i_wb_dat[ulm_pkg::MC_W-1:0];
        end

        // error flags: head character in fifo mode, newest in single mode
        // a read clears them, but an error arriving in that cycle still sets
        if (ls_read) begin
            state_next.par = 1'b0; // [RQ11]
            state_next.frm = 1'b0; // [RQ11]
            state_next.brk = 1'b0; // [RQ11]
            state_next.ovr = 1'b0; // [RQ11]
        end
        if (i_rx_head_load && i_rx_head_parity_err) begin
            state_next.par = 1'b1; // [RQ8] [RQ9]
        end
        if (i_rx_head_load && i_rx_head_frame_err) begin
            state_next.frm = 1'b1; // [RQ7] [RQ9]
        end
        if (i_rx_head_load && i_rx_head_break) begin
            state_next.brk = 1'b1; // [RQ6] [RQ9]
        end
        if (i_rx_overrun) begin
            state_next.ovr = 1'b1; // [RQ10]
        end

        state_next.rdy = i_rx_data_avail; // [RQ12]

        // summary flag survives a read while an erroneous byte is queued
        if (!i_fifo_mode) begin
            state_next.ferr = 1'b0; // [RQ2]
        end else if (i_rx_fifo_err_present) begin
            state_next.ferr = 1'b1; // [RQ1]
        end else if (ls_read) begin
            state_next.ferr = 1'b0; // [RQ2]
        end

        // holding buffer empty
        if (i_fifo_mode) begin
            state_next.hbe = i_tx_fifo_empty & ~i_tx_write; // [RQ5]
        end else if (i_tx_load) begin
            state_next.hbe = 1'b1; // [RQ4]
        end else if (i_tx_write) begin
            state_next.hbe = 1'b0; // [RQ5]
        end

        // idle uses the registered empty flag in single mode, the fifo otherwise
        if (i_fifo_mode) begin
            state_next.idle = i_tx_fifo_empty & i_tx_shift_empty; // [RQ3]
        end else begin
            state_next.idle = state_reg.hbe & i_tx_shift_empty; // [RQ3]
        end

        // level for the interrupt logic; the interrupt path itself is not altered
        state_next.hei = state_reg.hbe & i_holding_empty_irq_enable; // [RQ4] [RQ16]

        // serial line: transmitter data reaches the receiver in loopback
        state_next.ser_out = loop ? ulm_pkg::PIN_IDLE : i_tx_serial; // [RQ13]
        state_next.rxs = loop ? i_tx_serial : i_serial_input; // [RQ13] [RQ16]

        // handshake outputs; ring control bit never reaches a pin
        if (loop) begin
            state_next.dtr_n = ulm_pkg::PIN_IDLE; // [RQ14]
            state_next.rts_n = ulm_pkg::PIN_IDLE; // [RQ14]
        end else begin
            state_next.dtr_n = ~state_reg.mctl[ulm_pkg::MC_DTR]; // [RQ20]
            state_next.rts_n = ~state_reg.mctl[ulm_pkg::MC_RTS]; // [RQ19] [RQ18]
        end

        // modem input levels, pins cut off in loopback
        state_next.lvl[ulm_pkg::ML_CTS] =
            modem_level(loop, state_reg.mctl[ulm_pkg::MC_RTS], i_cts_n); // [RQ15] [RQ21]
        state_next.lvl[ulm_pkg::ML_DSR] =
            modem_level(loop, state_reg.mctl[ulm_pkg::MC_DTR], i_dsr_n); // [RQ15] [RQ21]
        state_next.lvl[ulm_pkg::ML_RI] =
            modem_level(loop, state_reg.mctl[ulm_pkg::MC_RI], i_ri_n); // [RQ15] [RQ18] [RQ21]
        state_next.lvl[ulm_pkg::ML_DCD] =
            modem_level(loop, state_reg.mctl[ulm_pkg::MC_IRQ], i_dcd_n); // [RQ15] [RQ21]

        // interrupt gate works the same in loopback
        state_next.irq = state_reg.mctl[ulm_pkg::MC_IRQ] & i_irq_request; // [RQ17] [RQ16]
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg.rdy <= 1'b0;
            state_reg.ovr <= 1'b0;
            state_reg.par <= 1'b0;
            state_reg.frm <= 1'b0;
            state_reg.brk <= 1'b0;
            state_reg.hbe <= ulm_pkg::HBE_RESET;
            state_reg.idle <= ulm_pkg::IDLE_RESET;
            state_reg.ferr <= 1'b0;
            state_reg.mctl <= ulm_pkg::MC_RESET;
            state_reg.dat <= ulm_pkg::DAT_RESET;
            state_reg.ser_out <= ulm_pkg::PIN_IDLE;
            state_reg.rxs <= ulm_pkg::PIN_IDLE;
            state_reg.dtr_n <= ulm_pkg::PIN_IDLE;
            state_reg.rts_n <= ulm_pkg::PIN_IDLE;
            state_reg.irq <= 1'b0;
            state_reg.hei <= 1'b0;
            state_reg.lvl <= ulm_pkg::ML_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // every output is a flop; pins lag their cause by one clock
    assign o_wb_dat = state_reg.dat;
    assign o_serial_output = state_reg.ser_out;
    assign o_rx_serial = state_reg.rxs;
    assign o_dtr_n = state_reg.dtr_n;
    assign o_rts_n = state_reg.rts_n;
    assign o_irq = state_reg.irq;
    assign o_modem_levels = state_reg.lvl;
    assign o_line_status = status_now;
    assign o_holding_empty_irq = state_reg.hei;
    assign o_loopback = state_reg.mctl[ulm_pkg::MC_LOOP];
endmodule

// File: ulm_core_sva.sv
// concurrent checks on the line status and modem control ports
module ulm_core_sva (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ulm_pkg::ADR_W-1:0] i_wb_adr,
    input wire logic o_wb_ack,
    input wire logic i_fifo_mode,
    input wire logic i_rx_head_load,
    input wire logic i_rx_head_parity_err,
    input wire logic i_rx_head_frame_err,
    input wire logic i_rx_head_break,
    input wire logic i_rx_overrun,
    input wire logic i_rx_data_avail,
    input wire logic i_tx_load,
    input wire logic i_tx_shift_empty,
    input wire logic i_irq_request,
    input wire logic o_serial_output,
    input wire logic o_dtr_n,
    input wire logic o_rts_n,
    input wire logic o_irq,
    input wire logic [ulm_pkg::REG_W-1:0] o_line_status,
    input wire logic o_loopback
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    logic rd_ls;
    assign rd_ls = i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack && i_wb_adr[7:2] == 6'h05;
    a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("no ack one cycle after request");
    a_ack_once: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    a_overrun_set: assert property (i_rx_overrun |=> o_line_status[1])
        else $error("overrun flag not set");
    a_parity_set: assert property (i_rx_head_load && i_rx_head_parity_err |=> o_line_status[2])
        else $error("parity flag not set");
    a_frame_set: assert property (i_rx_head_load && i_rx_head_frame_err |=> o_line_status[3])
        else $error("framing flag not set");
    a_break_set: assert property (i_rx_head_load && i_rx_head_break |=> o_line_status[4])
        else $error("break flag not set");
    a_read_clear: assert property (rd_ls && !i_rx_overrun && !i_rx_head_load |=>
        o_line_status[4:1] == 4'h0) else $error("status read left error flags");
    a_ready_follow: assert property (o_line_status[0] == $past(i_rx_data_avail))
        else $error("data ready does not follow input");
    a_single_sum: assert property (!i_fifo_mode && !$past(i_fifo_mode) |-> !o_line_status[7])
        else $error("summary flag set in single mode");
    a_idle_busy: assert property (!i_tx_shift_empty [*2] |=> !o_line_status[6])
        else $error("idle flag while shifter busy");
    a_hbe_load: assert property (!i_fifo_mode && i_tx_load |=> o_line_status[5])
        else $error("empty flag not set on load");
    a_loop_pins: assert property (o_loopback && $past(o_loopback) |->
        o_rts_n && o_dtr_n && o_serial_output) else $error("pins active in loopback");
    a_irq_cause: assert property (o_irq |-> $past(i_irq_request))
        else $error("interrupt without request");
    c_status_read: cover property (rd_ls);
    c_loop_irq: cover property (o_loopback && o_irq);
    c_summary: cover property ($rose(o_line_status[7]));
endmodule

bind ulm_core ulm_core_sva ulm_core_sva_inst (.i_core_clk, .i_sys_rst, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .o_wb_ack, .i_fifo_mode, .i_rx_head_load, .i_rx_head_parity_err,
    .i_rx_head_frame_err, .i_rx_head_break, .i_rx_overrun, .i_rx_data_avail, .i_tx_load,
    .i_tx_shift_empty, .i_irq_request, .o_serial_output, .o_dtr_n, .o_rts_n, .o_irq,
    .o_line_status, .o_loopback);

// File: ulm_modem_model.sv
// modem peripheral model on the handshake pins and serial line
module ulm_modem_model (
    input wire logic i_dtr_n,
    input wire logic i_rts_n,
    input wire logic i_ring_n,
    input wire logic i_tx_line,
    output logic o_cts_n,
    output logic o_dsr_n,
    output logic o_ri_n,
    output logic o_dcd_n,
    output logic o_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // null-modem echo, so pin polarity shows up in the level bits
    assign o_cts_n = i_rts_n;
    assign o_dsr_n = i_dtr_n;
    assign o_dcd_n = i_dtr_n;
    assign o_ri_n = i_ring_n;
    // line echoes the transmit pin; loopback isolation shows as a difference
    assign o_line = i_tx_line;
endmodule

// File: ulm_core_tb.sv
// register-level testbench for the line status and modem control block
module ulm_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk, i_sys_rst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, i_fifo_mode;
    logic [7:0] i_wb_adr, o_line_status;
    logic [3:0] i_wb_sel, o_modem_levels;
    logic [31:0] i_wb_dat, o_wb_dat, rd;
    logic i_rx_head_load, i_rx_head_parity_err, i_rx_head_frame_err, i_rx_head_break;
    logic i_rx_overrun, i_rx_data_avail, i_rx_fifo_err_present, i_tx_write, i_tx_load;
    logic i_tx_fifo_empty, i_tx_shift_empty, i_tx_serial, i_holding_empty_irq_enable;
    logic i_irq_request, ring_n, o_serial_output, o_rx_serial, o_dtr_n, o_rts_n, o_irq;
    logic o_holding_empty_irq, o_loopback;
    wire logic i_serial_input, i_cts_n, i_dsr_n, i_ri_n, i_dcd_n;
    logic [7:0] lvl [4] = '{8'h20, 8'h10, 8'h40, 8'h80};
    int n_errors = 0;
    int comparisons = 0;
    ulm_core ulm_core_inst (.*);
    ulm_modem_model ulm_modem_model_inst (.i_dtr_n(o_dtr_n), .i_rts_n(o_rts_n),
        .i_ring_n(ring_n), .i_tx_line(o_serial_output), .o_cts_n(i_cts_n),
        .o_dsr_n(i_dsr_n), .o_ri_n(i_ri_n), .o_dcd_n(i_dcd_n), .o_line(i_serial_input));
    task automatic print_verdict();
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    // holds the request until ack is sampled; bounded so a dead slave ends the run
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rdat);
        int n;
        n = 0;
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= adr;
        i_wb_dat <= wd;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 20);
        rdat = o_wb_dat;
        if (o_wb_ack !== 1'b1) begin
            n_errors++;
            print_verdict();
        end
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0, rd);
        chk(rd, exp);
    endtask
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    initial begin
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_fifo_mode, i_rx_head_load} = '0;
        {i_rx_head_parity_err, i_rx_head_frame_err, i_rx_head_break, i_rx_overrun} = '0;
        {i_rx_data_avail, i_rx_fifo_err_present, i_tx_write, i_tx_load} = '0;
        {i_holding_empty_irq_enable, i_irq_request} = '0;
        {i_tx_fifo_empty, i_tx_shift_empty, i_tx_serial, ring_n, i_sys_rst} = '1;
        i_wb_sel = 4'h1;
        cyc(16);
        i_sys_rst <= 1'b0;
        rd_chk(8'h14, 32'h60);
        chk({o_rts_n, o_dtr_n}, 2'b11);
        for (int v = 0; v < 8; v++) begin
            wb(1'b1, 8'h10, 32'hE0 | 32'(v), rd);
            cyc(2);
            chk({o_rts_n, o_dtr_n}, {~v[1], ~v[0]});
            rd_chk(8'h18, {24'h0, v[0], 1'b0, v[0], v[1], 4'h0});
            rd_chk(8'h10, 32'(v));
        end
        ring_n <= 1'b0;
        i_tx_serial <= 1'b0;
        cyc(3);
        rd_chk(8'h18, 32'hF0);
        chk({o_serial_output, o_rx_serial}, 2'b00);
        ring_n <= 1'b1;
        i_rx_data_avail <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            {i_rx_head_break, i_rx_head_frame_err, i_rx_head_parity_err, i_rx_overrun} <= 4'(1 << k);
            i_rx_head_load <= 1'b1;
            cyc(1);
            {i_rx_head_load, i_rx_head_break, i_rx_head_frame_err} <= '0;
            {i_rx_head_parity_err, i_rx_overrun} <= '0;
            cyc(1);
            rd_chk(8'h14, 32'h61 | (32'h2 << k));
            rd_chk(8'h14, 32'h61);
        end
        i_rx_data_avail <= 1'b0;
        cyc(2);
        fork
            wb(1'b0, 8'h14, 32'h0, rd);
            begin
                i_rx_overrun <= 1'b1;
                cyc(1);
                i_rx_overrun <= 1'b0;
            end
        join
        chk(rd, 32'h60);
        rd_chk(8'h14, 32'h62);
        i_fifo_mode <= 1'b1;
        i_rx_fifo_err_present <= 1'b1;
        cyc(2);
        rd_chk(8'h14, 32'hE0);
        rd_chk(8'h14, 32'hE0);
        i_rx_fifo_err_present <= 1'b0;
        i_tx_fifo_empty <= 1'b0;
        cyc(2);
        rd_chk(8'h14, 32'h80);
        rd_chk(8'h14, 32'h00);
        i_tx_fifo_empty <= 1'b1;
        i_fifo_mode <= 1'b0;
        i_rx_fifo_err_present <= 1'b1;
        i_holding_empty_irq_enable <= 1'b1;
        i_tx_write <= 1'b1;
        i_tx_shift_empty <= 1'b0;
        cyc(1);
        i_tx_write <= 1'b0;
        cyc(2);
        rd_chk(8'h14, 32'h00);
        i_tx_load <= 1'b1;
        cyc(1);
        i_tx_load <= 1'b0;
        cyc(2);
        chk(o_holding_empty_irq, 1'b1);
        rd_chk(8'h14, 32'h20);
        i_tx_shift_empty <= 1'b1;
        i_irq_request <= 1'b1;
        cyc(3);
        rd_chk(8'h14, 32'h60);
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, 8'h10, 32'hF0 | (32'h1 << k), rd);
            cyc(2);
            rd_chk(8'h18, {24'h0, lvl[k]});
            chk({o_irq, o_rts_n, o_dtr_n, o_serial_output, o_rx_serial},
                {k == 3, 4'hE});
            chk({o_loopback, o_modem_levels}, {1'b1, lvl[k][7:4]});
        end
        wb(1'b1, 8'h10, 32'h0, rd);
        cyc(2);
        chk(o_irq, 1'b0);
        rd_chk(8'h3C, 32'h0);
        wb(1'b1, 8'h14, 32'hFF, rd);
        rd_chk(8'h14, 32'h60);
        print_verdict();
    end
endmodule
